//--- inc/cap_pkg.sv
package cap_pkg;

  // Bit and symbol timing
  localparam int unsigned CAP_CLK_KHZ      = 200000;
  localparam int unsigned CAP_BIT_RATE_KHZ = 155520;
  localparam logic [18:0] CAP_NCO_MOD      = 19'(CAP_CLK_KHZ);
  localparam logic [18:0] CAP_NCO_INC      = 19'(CAP_BIT_RATE_KHZ);
  localparam logic [2:0]  CAP_SYM_BITS     = 3'h6;
  localparam logic [2:0]  CAP_SYM_LAST     = 3'h5;

  // Scrambler taps, bit index of x^n is n-1
  localparam int unsigned CAP_SCR_LEN      = 23;
  localparam int unsigned CAP_TAP_NET      = 17;
  localparam int unsigned CAP_TAP_USER     = 4;

  // Register map, byte addresses
  localparam logic [3:0]  CAP_OFS_CTRL     = 4'h0;
  localparam logic [3:0]  CAP_OFS_STATUS   = 4'h4;
  localparam logic [4:0]  CAP_CTRL_RESET   = 5'h00;

  // Control field positions
  localparam int unsigned CAP_CTRL_USER    = 0;
  localparam int unsigned CAP_CTRL_TXSOFF  = 1;
  localparam int unsigned CAP_CTRL_RXSOFF  = 2;
  localparam int unsigned CAP_CTRL_ONES    = 3;
  localparam int unsigned CAP_CTRL_FREE    = 4;

  // Status field positions
  localparam int unsigned CAP_STAT_RVALID  = 0;
  localparam int unsigned CAP_STAT_LOOP    = 1;
  localparam int unsigned CAP_STAT_CNT_LSB = 16;

  // Shaping filter taps, a short truncated approximation
  localparam int unsigned CAP_TAPS         = 4;
  localparam logic signed [4:0] CAP_I_COEF [CAP_TAPS] = '{5'sh03, 5'sh0F, 5'sh0F, 5'sh03};
  localparam logic signed [4:0] CAP_Q_COEF [CAP_TAPS] = '{5'sh1C, 5'sh17, 5'sh09, 5'sh04};

  typedef struct packed {
    logic signed [3:0] a_lvl;
    logic signed [3:0] b_lvl;
  } cap_sym_type;

  typedef struct packed {
    logic force_free;
    logic test_ones;
    logic rx_scr_off;
    logic tx_scr_off;
    logic user_role;
  } cap_ctrl_type;

  typedef enum logic [1:0] {
    CAP_BUS_IDLE = 2'b00,
    CAP_BUS_ACK  = 2'b01
  } cap_bus_state_type;

endpackage

//--- rtl/cap_scrambler.sv
`timescale 1ns/10ps
module cap_scrambler
  import cap_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic nrst,
  input  wire logic en,
  input  wire logic bypass,
  input  wire logic user_tap,
  input  wire logic descramble,
  input  wire logic din,
  output logic      dout
);

  logic [CAP_SCR_LEN-1:0] state_q;
  logic                   fb;
  logic                   shift_in;

  // Self-synchronizing: descrambler shifts the line bit, scrambler its own output
  assign fb       = state_q[CAP_SCR_LEN-1] ^ (user_tap ? state_q[CAP_TAP_USER] : state_q[CAP_TAP_NET]);
  assign dout     = bypass ? din : din ^ fb;
  assign shift_in = descramble ? din : dout;

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      state_q <= '0;
    else if (en)
      state_q <= {state_q[CAP_SCR_LEN-2:0], shift_in};
  end

endmodule

//--- rtl/cap_symbol_map.sv
`timescale 1ns/10ps
module cap_symbol_map
  import cap_pkg::*;
(
  input  wire logic [5:0]  bits_in,
  output cap_sym_type      sym_out,
  input  wire cap_sym_type sym_in,
  output logic [5:0]       bits_out
);

  function automatic logic signed [3:0] gray_level(input logic neg, input logic [1:0] g);
    logic [3:0] mag;
    mag = 4'h1;
    case (g)
      2'b00:   mag = 4'h1;
      2'b01:   mag = 4'h3;
      2'b11:   mag = 4'h5;
      default: mag = 4'h7;
    endcase
    return neg ? -$signed(mag) : $signed(mag);
  endfunction

  // Slicer: nearest level, so a noisy level still decodes
  function automatic logic [2:0] slice(input logic signed [3:0] lvl);
    logic [3:0] mag;
    logic [1:0] g;
    mag = lvl[3] ? 4'(-lvl) : 4'(lvl);
    if (mag <= 4'h2)
      g = 2'b00;
    else if (mag <= 4'h4)
      g = 2'b01;
    else if (mag <= 4'h6)
      g = 2'b11;
    else
      g = 2'b10;
    return {lvl[3], g};
  endfunction

  logic [2:0] a_sl;
  logic [2:0] b_sl;

  // b1 b2 pick the quadrant by sign, b3 b5 and b4 b6 the magnitudes
  assign sym_out.a_lvl = gray_level(bits_in[5], {bits_in[3], bits_in[1]});
  assign sym_out.b_lvl = gray_level(bits_in[4], {bits_in[2], bits_in[0]});
  assign a_sl          = slice(sym_in.a_lvl);
  assign b_sl          = slice(sym_in.b_lvl);
  assign bits_out      = {a_sl[2], b_sl[2], a_sl[1], b_sl[1], a_sl[0], b_sl[0]};

endmodule

//--- rtl/cap_phy_core.sv
// The register addresses and the Avalon-MM slave port were decided locally.
`timescale 1ns/10ps
module cap_phy_core
  import cap_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        tx_bit,
  output logic             tx_bit_take,
  input  wire logic        rec_bit_tick,
  input  wire logic        rec_clk_valid,
  input  wire cap_sym_type line_input_port,
  input  wire logic        line_input_valid,
  output logic             rx_bit,
  output logic             rx_bit_valid,
  output cap_sym_type      tx_sym,
  output logic             tx_sym_valid,
  output logic [11:0]      line_output_port,
  output logic             line_output_valid
);

  cap_ctrl_type      ctrl_q;
  cap_bus_state_type bus_q;
  logic [31:0]       rdata_q;
  logic [15:0]       sym_cnt_q;
  logic [17:0]       nco_q;
  logic              loop_q;
  logic [2:0]        bit_cnt_q;
  logic [4:0]        grp_q;
  logic [2:0]        ones_run_q;
  logic [5:0]        rx_grp_q;
  logic [2:0]        rx_cnt_q;
  logic              rx_bit_q;
  logic              rx_valid_q;
  cap_sym_type       sym_q;
  logic              sym_valid_q;
  cap_sym_type       hist_q [CAP_TAPS];
  logic signed [11:0] sum_prev_q;
  logic [11:0]       line_q;
  logic              line_valid_q;
  logic              line_out_valid_q;

  // Avalon slave: one wait cycle, then the answer edge
  logic bus_req;
  logic bus_ack;
  logic sel_ctrl;
  logic sel_status;
  logic [31:0] rd_mux;
  assign bus_req         = avs_read | avs_write;
  assign bus_ack         = bus_req & (bus_q == CAP_BUS_ACK);
  assign avs_waitrequest = bus_req & ~bus_ack;
  assign avs_readdata    = rdata_q;
  assign sel_ctrl        = avs_address == CAP_OFS_CTRL;
  assign sel_status      = avs_address == CAP_OFS_STATUS;

  logic [31:0] status_word;
  assign status_word = {sym_cnt_q, 14'h0000, loop_q, rec_clk_valid};
  assign rd_mux = sel_ctrl ? {27'h0000000, ctrl_q} : sel_status ? status_word : 32'h00000000;

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      bus_q   <= CAP_BUS_IDLE;
      rdata_q <= 32'h00000000;
      ctrl_q  <= cap_ctrl_type'(CAP_CTRL_RESET);
    end
    else
    begin
      bus_q <= (bus_req && !bus_ack) ? CAP_BUS_ACK : CAP_BUS_IDLE;
      if (avs_read && !bus_ack)
        rdata_q <= rd_mux;
      if (avs_write && bus_ack && sel_ctrl)
        ctrl_q <= cap_ctrl_type'(avs_writedata[4:0]);
    end
  end

  // Free-running bit tick: exact nominal rate from the system clock
  logic [18:0] nco_sum;
  logic        nco_tick;
  assign nco_sum  = {1'b0, nco_q} + CAP_NCO_INC;
  assign nco_tick = nco_sum >= CAP_NCO_MOD;

  // Loop timing only for the user role with a live recovered clock
  logic loop_want;
  logic loop_tick;
  logic tx_tick;
  logic switch_ok;
  assign loop_want = ctrl_q.user_role & rec_clk_valid & ~ctrl_q.force_free;
  assign loop_tick = rec_bit_tick & rec_clk_valid;
  assign tx_tick   = loop_q ? loop_tick : nco_tick;
  // Source may only change between ticks, and on a symbol boundary unless the recovered clock is not valid
  assign switch_ok = !tx_tick && (bit_cnt_q == 3'h0 || !rec_clk_valid);
  assign tx_bit_take = tx_tick;

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      nco_q  <= 18'h00000;
      loop_q <= 1'b0;
    end
    else
    begin
      nco_q <= nco_tick ? 18'(nco_sum - CAP_NCO_MOD) : nco_sum[17:0];
      if (switch_ok)
        loop_q <= loop_want;
    end
  end

  // Transmit: scramble, optional all-ones, group six bits
  logic tx_scr;
  logic enc_in;
  logic [5:0] tx_grp;
  cap_sym_type map_sym;
  logic [5:0]  rx_bits;
  cap_scrambler u_tx_scr (
    .clk_sys    (clk_sys),
    .nrst       (nrst),
    .en         (tx_tick),
    .bypass     (ctrl_q.tx_scr_off),
    .user_tap   (ctrl_q.user_role),
    .descramble (1'b0),
    .din        (tx_bit),
    .dout       (tx_scr)
  );
  assign enc_in = ctrl_q.test_ones | tx_scr;
  assign tx_grp = {grp_q, enc_in};

  cap_symbol_map u_map (
    .bits_in  (tx_grp),
    .sym_out  (map_sym),
    .sym_in   (line_input_port),
    .bits_out (rx_bits)
  );

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      bit_cnt_q   <= 3'h0;
      grp_q       <= 5'h00;
      sym_q       <= '0;
      sym_valid_q <= 1'b0;
      sym_cnt_q   <= 16'h0000;
      ones_run_q  <= 3'h0;
    end
    else
    begin
      sym_valid_q <= tx_tick && bit_cnt_q == CAP_SYM_LAST;
      if (tx_tick)
      begin
        grp_q      <= tx_grp[4:0];
        bit_cnt_q  <= (bit_cnt_q == CAP_SYM_LAST) ? 3'h0 : 3'(bit_cnt_q + 3'h1);
        ones_run_q <= !enc_in ? 3'h0 : (ones_run_q == 3'h7) ? 3'h7 : 3'(ones_run_q + 3'h1);
        if (bit_cnt_q == CAP_SYM_LAST)
        begin
          sym_q     <= map_sym;
          sym_cnt_q <= 16'(sym_cnt_q + 16'h0001);
        end
      end
      else if (switch_ok && loop_q != loop_want && bit_cnt_q != 3'h0)
        bit_cnt_q <= 3'h0;
    end
  end
  assign tx_sym       = sym_q;
  assign tx_sym_valid = sym_valid_q;

  // Shaping: a short FIR per component, then in-phase minus quadrature
  logic signed [10:0] i_terms [CAP_TAPS];
  logic signed [10:0] q_terms [CAP_TAPS];
  logic signed [10:0] i_part  [CAP_TAPS+1];
  logic signed [10:0] q_part  [CAP_TAPS+1];
  logic signed [11:0] sum_now;
  assign i_part[0] = 11'sh000;
  assign q_part[0] = 11'sh000;
  for (genvar k = 0; k < CAP_TAPS; k++)
  begin : g_tap
    assign i_terms[k]  = 11'(hist_q[k].a_lvl * CAP_I_COEF[k]);
    assign q_terms[k]  = 11'(hist_q[k].b_lvl * CAP_Q_COEF[k]);
    assign i_part[k+1] = 11'(i_part[k] + i_terms[k]);
    assign q_part[k+1] = 11'(q_part[k] + q_terms[k]);
  end
  assign sum_now = 12'(i_part[CAP_TAPS] - q_part[CAP_TAPS]);

  logic signed [12:0] lp_sum;
  assign lp_sum = 13'(sum_now) + 13'(sum_prev_q);

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      for (int k = 0; k < CAP_TAPS; k++)
        hist_q[k] <= '0;
      sum_prev_q   <= 12'sh000;
      line_q       <= 12'h000;
      line_valid_q <= 1'b0;
      line_out_valid_q <= 1'b0;
    end
    else
    begin
      line_valid_q <= sym_valid_q;
      // Valid follows line_q, which loads one cycle after the history shift
      line_out_valid_q <= line_valid_q;
      if (sym_valid_q)
      begin
        hist_q[0] <= sym_q;
        for (int k = 1; k < CAP_TAPS; k++)
          hist_q[k] <= hist_q[k-1];
      end
      if (line_valid_q)
      begin
        // Two-point average as low-pass; keeps one extra bit of headroom
        line_q     <= lp_sum[12:1];
        sum_prev_q <= sum_now;
      end
    end
  end
  assign line_output_port  = line_q;
  assign line_output_valid = line_out_valid_q;

  // Receive: unpack six bits per symbol on recovered ticks, descramble
  logic rx_shift;
  logic rx_desc;
  assign rx_shift = rec_bit_tick && rx_cnt_q != 3'h0;
  cap_scrambler u_rx_scr (
    .clk_sys    (clk_sys),
    .nrst       (nrst),
    .en         (rx_shift),
    .bypass     (ctrl_q.rx_scr_off),
    .user_tap   (~ctrl_q.user_role),
    .descramble (1'b1),
    .din        (rx_grp_q[5]),
    .dout       (rx_desc)
  );

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      rx_grp_q   <= 6'h00;
      rx_cnt_q   <= 3'h0;
      rx_bit_q   <= 1'b0;
      rx_valid_q <= 1'b0;
    end
    else
    begin
      rx_valid_q <= rx_shift;
      if (rx_shift)
        rx_bit_q <= rx_desc;
      // A new symbol restarts the group; a late tail is dropped
      if (line_input_valid)
      begin
        rx_grp_q <= rx_bits;
        rx_cnt_q <= CAP_SYM_BITS;
      end
      else if (rx_shift)
      begin
        rx_grp_q <= {rx_grp_q[4:0], 1'b0};
        rx_cnt_q <= 3'(rx_cnt_q - 3'h1);
      end
    end
  end
  assign rx_bit       = rx_bit_q;
  assign rx_bit_valid = rx_valid_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  chk_group_six: assert property (tx_sym_valid |-> $past(tx_tick) && $past(bit_cnt_q) == CAP_SYM_LAST)
    else $error("symbol without six bits");
  chk_ones_symbol: assert property (tx_sym_valid && ones_run_q >= 3'h6 |-> tx_sym.a_lvl == -4'sh5 && tx_sym.b_lvl == -4'sh5)
    else $error("all-ones group gave wrong symbol");
  chk_switch_edge: assert property ($changed(loop_q) |-> !$past(tx_tick))
    else $error("clock source switched on a tick");
  chk_nco_spacing: assert property (!nco_tick |=> nco_tick)
    else $error("free-running tick gap too long");
  chk_tick_source: assert property (tx_tick == (loop_q ? loop_tick : nco_tick))
    else $error("transmit tick from wrong source");
  chk_fall_back: assert property ($fell(rec_clk_valid) && loop_q |=> !loop_q)
    else $error("no fallback to free-running clock");
  chk_network_free: assert property (!ctrl_q.user_role && !tx_tick |=> !loop_q)
    else $error("network role is loop timed");
  chk_line_timing: assert property (tx_sym_valid |=> ##1 line_output_valid)
    else $error("line sample not produced");
  chk_rx_tick: assert property (rx_bit_valid |-> $past(rec_bit_tick) && $past(rx_cnt_q) != 3'h0)
    else $error("receive bit off a recovered tick");
  chk_bus_wait: assert property ($rose(bus_req) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer timing wrong");

  cov_loop_on:  cover property ($rose(loop_q));
  cov_fallback: cover property ($fell(loop_q));
  cov_rx_sym:   cover property (line_input_valid ##[1:20] rx_bit_valid);

endmodule

//--- test/cap_tb_fn.svh
function automatic logic signed [3:0] cap_lvl(input logic s, input logic [1:0] g);
  logic signed [3:0] m;
  case (g)
    2'b00: m = 4'sh1;
    2'b01: m = 4'sh3;
    2'b11: m = 4'sh5;
    default: m = 4'sh7;
  endcase
  return s ? -m : m;
endfunction

// Bit 5 is the first bit of the group
function automatic logic [7:0] cap_map(input logic [5:0] b);
  return {cap_lvl(b[5], {b[3], b[1]}), cap_lvl(b[4], {b[2], b[0]})};
endfunction

function automatic logic cap_pay(input int k);
  return k[0] ^ k[2] ^ k[5] ^ (k[4] & k[1]);
endfunction

//--- test/cap_far_end.sv
`timescale 1ns/10ps
module cap_far_end
  import cap_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic nrst,
  input  wire logic run,
  input  wire logic net_poly,
  input  wire logic plain,
  input  wire logic slow,
  output cap_sym_type sym,
  output logic      sym_valid,
  output logic      bit_tick,
  output logic      clk_ok
);
  `include "cap_tb_fn.svh"
  logic [3:0]  ph_q;
  logic [22:0] hist_q;
  int          k_q;

  // Scrambler history survives role changes, so the near descrambler stays in step
  always_ff @(posedge clk_sys)
  begin : step
    logic [22:0] h;
    logic [5:0]  g;
    logic        y;
    if (!nrst || !run)
    begin
      ph_q      <= 4'h0;
      k_q       <= 0;
      hist_q    <= 23'h0;
      sym       <= 8'h5A;
      sym_valid <= 1'b0;
      bit_tick  <= 1'b0;
      clk_ok    <= 1'b0;
    end
    else
    begin
      clk_ok   <= 1'b1;
      bit_tick <= ph_q <= 4'h5;
      if (ph_q == (slow ? 4'hF : 4'h7))
      begin
        h = hist_q;
        for (int i = 0; i < 6; i++)
        begin
          y = cap_pay(k_q + i) ^ (!plain & (h[22] ^ (net_poly ? h[17] : h[4])));
          h = {h[21:0], y};
          g[5 - i] = y;
        end
        ph_q      <= 4'h0;
        hist_q    <= h;
        k_q       <= k_q + 6;
        sym       <= cap_map(g);
        sym_valid <= 1'b1;
      end
      else
      begin
        ph_q      <= ph_q + 4'h1;
        sym       <= ~sym;
        sym_valid <= 1'b0;
      end
    end
  end
endmodule

//--- test/tb_top.sv
`timescale 1ns/10ps
module tb_top
  import cap_pkg::*;
;
  `include "cap_tb_fn.svh"
  logic        clk_sys, nrst, avs_read, avs_write, tx_bit, run, slow, role, plain, chk_tx, chk_rx;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rdq;
  logic        avs_waitrequest, tx_bit_take, rec_bit_tick, rec_clk_valid, line_input_valid;
  logic        rx_bit, rx_bit_valid, tx_sym_valid, line_output_valid;
  cap_sym_type line_input_port, tx_sym;
  logic [11:0] line_output_port;
  logic [1:0]  mode;
  logic [22:0] th;
  logic [5:0]  tg;
  logic [7:0]  eq[$];
  int          bad_count, checks, tk, tw, sw, rw, lw, ridx, isum, qsum;

  cap_phy_core dut (.clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .tx_bit(tx_bit), .tx_bit_take(tx_bit_take),
    .rec_bit_tick(rec_bit_tick), .rec_clk_valid(rec_clk_valid), .line_input_port(line_input_port),
    .line_input_valid(line_input_valid), .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid), .tx_sym(tx_sym),
    .tx_sym_valid(tx_sym_valid), .line_output_port(line_output_port), .line_output_valid(line_output_valid));

  cap_far_end far (.clk_sys(clk_sys), .nrst(nrst), .run(run), .net_poly(role), .plain(plain), .slow(slow),
    .sym(line_input_port), .sym_valid(line_input_valid), .bit_tick(rec_bit_tick), .clk_ok(rec_clk_valid));

  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      bad_count++;
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= ~wr;
    avs_writedata <= d;
    // Hold until the edge that samples waitrequest low; the watchdog ends a hang
    do
      @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0);
    rdq = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rdq & m, e);
  endtask

  // Counts gathered by the monitor over n cycles; loop timing compares takes to ticks
  task automatic rate(input int n, input logic lp);
    int e;
    e = n * CAP_BIT_RATE_KHZ / CAP_CLK_KHZ;
    @(posedge clk_sys);
    tw = 0;
    sw = 0;
    rw = 0;
    lw = 0;
    repeat (n) @(posedge clk_sys);
    if (lp)
      chk(32'(tw >= rw - 1 && tw <= rw + 1), 32'h1);
    else
      chk(32'(tw >= e && tw <= e + 1), 32'h1);
    chk(32'(sw * 6 >= tw - 6 && sw * 6 <= tw + 6), 32'h1);
    chk(32'(lw >= sw - 1 && lw <= sw + 1), 32'h1);
  endtask

  task automatic tx_mode(input logic [31:0] c, input logic [1:0] m);
    chk_tx = 1'b0;
    bus(1'b1, 4'h0, c);
    mode = m;
    repeat (80) @(posedge clk_sys);
    chk_tx = 1'b1;
    repeat (200) @(posedge clk_sys);
    chk_tx = 1'b0;
    done("transmit mode");
  endtask

  task automatic rx_cfg(input logic [31:0] c, input logic p, input logic r, input logic s);
    chk_rx = 1'b0;
    bus(1'b1, 4'h0, c);
    plain <= p;
    role  <= r;
    slow  <= s;
    repeat (100) @(posedge clk_sys);
    chk_rx = 1'b1;
    rate(400, r);
    chk_rx = 1'b0;
    rd(4'h4, 32'h3, {30'h0, r, 1'b1});
    done("receive");
  endtask

  always @(posedge clk_sys)
    tx_bit <= cap_pay(tk);

  // Sampled mid-cycle so registered outputs are settled
  always @(negedge clk_sys)
  begin : mon
    logic y;
    if (!nrst || !run)
      ridx = 0;
    if (!nrst)
    begin
      tk = 0;
      th = 23'h0;
      tg = 6'h0;
      eq.delete();
    end
    else
    begin
      if (tx_bit_take === 1'b1)
      begin
        y = (mode == 2'h2) | ((mode == 2'h1) ? tx_bit : tx_bit ^ th[22] ^ th[17]);
        th = {th[21:0], y};
        tg = {tg[4:0], y};
        tk++;
        tw++;
        if (tk % 6 == 0)
          eq.push_back(cap_map(tg));
      end
      if (tx_sym_valid === 1'b1)
      begin
        sw++;
        if (chk_tx && eq.size() > 0)
          chk(32'(tx_sym), 32'(eq[0]));
        if (eq.size() > 0)
          eq.delete(0);
      end
      rw += int'(rec_bit_tick === 1'b1);
      lw += int'(line_output_valid === 1'b1);
      if (line_output_valid === 1'b1 && chk_tx && mode == 2'h2)
        chk(32'(line_output_port), 32'({20'h0, 12'(5 * (qsum - isum))}));
      if (rx_bit_valid === 1'b1)
      begin
        if (chk_rx)
          chk(32'(rx_bit), 32'(cap_pay(ridx)));
        ridx++;
      end
    end
  end

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    complete_run();
  end

  initial
  begin
    nrst = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    tx_bit = 1'b0;
    run = 1'b0;
    slow = 1'b0;
    role = 1'b0;
    plain = 1'b0;
    mode = 2'h0;
    chk_tx = 1'b1;
    chk_rx = 1'b0;
    isum = 0;
    qsum = 0;
    for (int k = 0; k < CAP_TAPS; k++)
    begin
      isum += int'(CAP_I_COEF[k]);
      qsum += int'(CAP_Q_COEF[k]);
    end
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(4'h0, 32'hFFFFFFFF, 32'h0);
    rd(4'h4, 32'h0000FFFF, 32'h0);
    bus(1'b1, 4'h8, 32'h1F);
    bus(1'b1, 4'h4, 32'h3);
    rd(4'h8, 32'hFFFFFFFF, 32'h0);
    rd(4'h0, 32'hFFFFFFFF, 32'h0);
    done("registers");
    rate(1000, 1'b0);
    done("free rate");
    tx_mode(32'h02, 2'h1);
    tx_mode(32'h08, 2'h2);
    run <= 1'b1;
    rx_cfg(32'h0, 1'b0, 1'b0, 1'b0);
    rx_cfg(32'h4, 1'b1, 1'b0, 1'b0);
    rx_cfg(32'h1, 1'b0, 1'b1, 1'b1);
    bus(1'b1, 4'h0, 32'h11);
    repeat (20) @(posedge clk_sys);
    rd(4'h4, 32'h3, 32'h1);
    rate(1000, 1'b0);
    bus(1'b1, 4'h0, 32'h1);
    run <= 1'b0;
    repeat (20) @(posedge clk_sys);
    rd(4'h4, 32'h3, 32'h0);
    rate(1000, 1'b0);
    done("fallback");
    nrst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(4'h0, 32'hFFFFFFFF, 32'h0);
    done("second reset");
    complete_run();
  end
endmodule
